//--- hw/ces_exception_state.sv
// Exception state, privilege decode, watchpoint and miss context with APB access
//
// Notes on behaviour
// - Kernel wide addressing follows kernel_wide_addr; ops always
// - Supervisor/user wide mode follow own bits
// - Space access checked against current privilege
// - Soft-reset flag 0 cold, 1 soft/NMI
// - Exception stores 5-bit code at bits 6:2
// - Cause read-only except software pending bits
// - Bit 31 marks exception in delay slot
// - Unusable coprocessor number stored at 29:28
// - Fixed exception code encoding, rest reserved
// - Count equal compare sets timer pending bit
// - Pending 6:2 mirror request lines directly
// - Software pending bits raise enabled interrupt
// - Return address is faulting or branch PC
// - Exception level set blocks return address update
// - Watch compares physical address bits 31:3
// - Load/store watch enables gate watch exception
// - Miss stores vaddr 39:11 at 32:4
// - Miss stores vaddr 63:62 at 34:33
// - Page table base is software only
// - Reserved fields read zero, written zero
// - Privilege field decodes user/supervisor else kernel
// - Entry sets exception level, return clears
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module ces_exception_state #(
    parameter int WATCH_HI_W = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ces_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Exception entry and return from the pipeline
    input wire logic exc_valid,
    input wire logic [4:0] exc_code,
    input wire logic exc_in_delay,
    input wire logic [63:0] exc_pc,
    input wire logic [63:0] exc_branch_pc,
    input wire logic [1:0] exc_cop_num,
    input wire logic exc_map_miss,
    input wire logic [63:0] exc_vaddr,
    input wire logic exc_return,
    input wire logic soft_reset_req,
    input wire logic map_shutdown_req,
    // Interrupt request lines
    input wire logic [4:0] irq_lines,
    output logic irq_request,
    // Memory reference for watch and space checks
    input wire logic mem_valid,
    input wire logic mem_is_load,
    input wire logic mem_is_store,
    input wire logic [31:0] mem_paddr,
    input wire logic [1:0] acc_space,
    output logic watch_hit,
    output logic acc_allowed,
    // Mode state
    output logic mode_kernel,
    output logic mode_supv,
    output logic mode_user,
    output logic wide_addr_ok,
    output logic wide_ops_ok,
    output logic exception_level,
    output logic error_level,
    output logic boot_vector_sel,
    output logic map_shutdown_flag
);
    import ces_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] status;
    logic [31:0] next_status;
    logic [4:0] exception_code;
    logic delay_slot_flag;
    logic [1:0] cop_num;
    logic [1:0] sw_pending;
    logic timer_pending;
    logic [63:0] exception_return_pc;
    logic [63:0] next_ret_pc;
    logic [28:0] watch_phys_addr;
    logic watch_load_en;
    logic watch_store_en;
    logic [WATCH_HI_W-1:0] watch_address_high;
    logic [28:0] page_table_base;
    logic [1:0] space_type;
    logic [28:0] failed_page_pair;
    logic [31:0] compare;
    logic [31:0] count;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic wr_acc = psel && penable && pwrite;
    wire logic wr_status = wr_acc && (paddr == ADDR_STATUS);
    wire logic wr_cause = wr_acc && (paddr == ADDR_CAUSE);
    wire logic wr_ret_lo = wr_acc && (paddr == ADDR_RET_LO);
    wire logic wr_ret_hi = wr_acc && (paddr == ADDR_RET_HI);
    wire logic wr_wlo = wr_acc && (paddr == ADDR_WATCH_LO);
    wire logic wr_whi = wr_acc && (paddr == ADDR_WATCH_HI);
    wire logic wr_xhi = wr_acc && (paddr == ADDR_XCTX_HI);
    wire logic wr_compare = wr_acc && (paddr == ADDR_COMPARE);
    wire logic wr_count = wr_acc && (paddr == ADDR_COUNT);
    wire logic addr_hit = (paddr[1:0] == 2'h0) && (paddr <= ADDR_COUNT);

    // ------------------------------------------------------------
    // Mode and privilege decode
    // ------------------------------------------------------------
    wire logic exc_lvl = status[ST_EXC_LVL];
    wire logic err_lvl = status[ST_ERR_LVL];
    wire logic [1:0] privilege_mode = status[ST_PRIV_LO+1:ST_PRIV_LO];
    wire logic [7:0] irq_mask = status[ST_MASK_LO+7:ST_MASK_LO];
    wire logic lvl_clear = !exc_lvl && !err_lvl;
    wire logic is_user = lvl_clear && (privilege_mode == PRIV_USER);
    wire logic is_supv = lvl_clear && (privilege_mode == PRIV_SUPV);
    wire logic is_kern = !is_user && !is_supv;
    wire logic kernel_wide_addr = status[ST_K_WIDE];
    wire logic supv_wide_mode = status[ST_S_WIDE];
    wire logic user_wide_mode = status[ST_U_WIDE];

    assign mode_user = is_user;
    assign mode_supv = is_supv;
    assign mode_kernel = is_kern;
    assign wide_addr_ok = is_kern ? kernel_wide_addr :
                          is_supv ? supv_wide_mode : user_wide_mode;
    assign wide_ops_ok = is_kern || (is_supv && supv_wide_mode)
                         || (is_user && user_wide_mode);
    // Undefined space code 10 is treated as kernel space
    assign acc_allowed = (acc_space == SPACE_USER)
                         || ((acc_space == SPACE_SUPV) && !is_user)
                         || (acc_space[1] && is_kern);
    assign exception_level = exc_lvl;
    assign error_level = err_lvl;
    assign boot_vector_sel = status[ST_BOOT];
    assign map_shutdown_flag = status[ST_SHUT];

    // ------------------------------------------------------------
    // Interrupt pending and request
    // ------------------------------------------------------------
    wire logic [7:0] pending_irq = {timer_pending, irq_lines, sw_pending};
    wire logic timer_hit = (count == compare);
    assign irq_request = status[ST_IE] && lvl_clear && |(pending_irq & irq_mask);

    // ------------------------------------------------------------
    // Watchpoint
    // ------------------------------------------------------------
    // Combinational so the pipeline can fault the same reference
    wire logic watch_addr_eq = (mem_paddr[31:3] == watch_phys_addr);
    assign watch_hit = mem_valid && watch_addr_eq
                       && ((mem_is_load && watch_load_en)
                       || (mem_is_store && watch_store_en));

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    always_comb begin
        next_status = status;
        if (wr_status) begin
            next_status = (pwdata & STATUS_WMASK) | (status & ~STATUS_WMASK);
        end
        if (exc_return) begin
            next_status[ST_EXC_LVL] = 1'b0;
        end
        if (exc_valid) begin
            next_status[ST_EXC_LVL] = 1'b1;
        end
        if (map_shutdown_req) begin
            next_status[ST_SHUT] = 1'b1;
        end
        if (soft_reset_req) begin
            next_status[ST_ERR_LVL] = 1'b1;
            next_status[ST_BOOT] = 1'b1;
            next_status[ST_SHUT] = 1'b0;
            next_status[ST_SOFT] = 1'b1;
        end
    end

    // Cold reset leaves soft_reset_flag at 0
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            status <= STATUS_RST;
        end else begin
            status <= next_status;
        end
    end

    // ------------------------------------------------------------
    // Cause
    // ------------------------------------------------------------
    // Code and flag track the latest exception even while nested
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            exception_code <= CODE_INT;
            delay_slot_flag <= 1'b0;
            cop_num <= 2'h0;
        end else if (exc_valid) begin
            exception_code <= exc_code;
            delay_slot_flag <= exc_in_delay;
            if (exc_code == CODE_COP_UNUSABLE) begin
                cop_num <= exc_cop_num;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sw_pending <= 2'h0;
        end else if (wr_cause) begin
            sw_pending <= pwdata[CA_PEND_LO+1:CA_PEND_LO];
        end
    end

    // A match in the cycle of a compare write still sets the bit
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            timer_pending <= 1'b0;
        end else if (timer_hit) begin
            timer_pending <= 1'b1;
        end else if (wr_compare) begin
            timer_pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Timer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count <= 32'h0000_0000;
            compare <= 32'hFFFF_FFFF;
        end else begin
            count <= wr_count ? pwdata : count + 32'h0000_0001;
            if (wr_compare) begin
                compare <= pwdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Exception return address
    // ------------------------------------------------------------
    always_comb begin
        next_ret_pc = exception_return_pc;
        if (wr_ret_lo) begin
            next_ret_pc[31:0] = pwdata;
        end
        if (wr_ret_hi) begin
            next_ret_pc[63:32] = pwdata;
        end
        // Hardware entry beats a software write in the same cycle
        if (exc_valid && !exc_lvl) begin
            next_ret_pc = exc_in_delay ? exc_branch_pc : exc_pc;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            exception_return_pc <= 64'h0000_0000_0000_0000;
        end else begin
            exception_return_pc <= next_ret_pc;
        end
    end

    // ------------------------------------------------------------
    // Watch registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            watch_phys_addr <= 29'h0000_0000;
            watch_load_en <= 1'b0;
            watch_store_en <= 1'b0;
            watch_address_high <= '0;
        end else begin
            if (wr_wlo) begin
                watch_phys_addr <= pwdata[31:3];
                watch_load_en <= pwdata[1];
                watch_store_en <= pwdata[0];
            end
            if (wr_whi) begin
                watch_address_high <= pwdata[WATCH_HI_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Wide miss context
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            page_table_base <= 29'h0000_0000;
            space_type <= SPACE_USER;
            failed_page_pair <= 29'h0000_0000;
        end else begin
            if (wr_xhi) begin
                page_table_base <= pwdata[31:3];
            end
            if (exc_valid && exc_map_miss) begin
                failed_page_pair <= exc_vaddr[39:11];
                space_type <= exc_vaddr[63:62];
            end
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire logic [31:0] cause_rd = {delay_slot_flag, 1'b0, cop_num, 12'h000,
                                  pending_irq, 1'b0, exception_code, 2'h0};
    wire logic [31:0] wlo_rd = {watch_phys_addr, 1'b0, watch_load_en, watch_store_en};
    wire logic [31:0] whi_rd = {{(32-WATCH_HI_W){1'b0}}, watch_address_high};
    wire logic [31:0] xlo_rd = {failed_page_pair[27:0], 4'h0};
    wire logic [31:0] xhi_rd = {page_table_base, space_type, failed_page_pair[28]};
    wire logic [31:0] rd_mux =
        (paddr == ADDR_STATUS) ? status :
        (paddr == ADDR_CAUSE) ? cause_rd :
        (paddr == ADDR_RET_LO) ? exception_return_pc[31:0] :
        (paddr == ADDR_RET_HI) ? exception_return_pc[63:32] :
        (paddr == ADDR_WATCH_LO) ? wlo_rd :
        (paddr == ADDR_WATCH_HI) ? whi_rd :
        (paddr == ADDR_XCTX_LO) ? xlo_rd :
        (paddr == ADDR_XCTX_HI) ? xhi_rd :
        (paddr == ADDR_COMPARE) ? compare :
        (paddr == ADDR_COUNT) ? count : 32'h0000_0000;

    // Sampled in the setup cycle; zero wait states
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_entry_sets_lvl: assert property (@(posedge clk_sys) disable iff (!reset_n)
        exc_valid |=> exc_lvl && mode_kernel)
        else $error("exception entry did not raise exception level");

    chk_retpc_held: assert property (@(posedge clk_sys) disable iff (!reset_n)
        exc_valid && exc_lvl && !wr_ret_lo && !wr_ret_hi |=> $stable(exception_return_pc))
        else $error("return address overwritten while exception level set");

    chk_retpc_loaded: assert property (@(posedge clk_sys) disable iff (!reset_n)
        exc_valid && !exc_lvl |=> exception_return_pc ==
            ($past(exc_in_delay) ? $past(exc_branch_pc) : $past(exc_pc)))
        else $error("return address not loaded on entry");

    chk_code_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
        exc_valid |=> cause_rd[6:2] == $past(exc_code) && cause_rd[31] == $past(exc_in_delay))
        else $error("cause code and delay flag not updated together");

    chk_timer_sets: assert property (@(posedge clk_sys) disable iff (!reset_n)
        timer_hit |=> cause_rd[15] ##1 (cause_rd[15] || $past(wr_compare)))
        else $error("timer pending bit not set on count match");

    chk_soft_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
        soft_reset_req |=> status[ST_SOFT] && err_lvl && boot_vector_sel && !map_shutdown_flag)
        else $error("soft reset state not applied");

    chk_kern_space: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (acc_space == SPACE_KERN) && (privilege_mode == PRIV_USER) && lvl_clear
            |-> !acc_allowed)
        else $error("kernel space allowed outside kernel mode");

    chk_sw_pending: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_cause && !exc_valid
            |=> cause_rd[9:8] == $past(pwdata[9:8]) && $stable(exception_code))
        else $error("software pending write wrong or touched read-only bits");

    chk_base_kept: assert property (@(posedge clk_sys) disable iff (!reset_n)
        exc_valid && exc_map_miss && !wr_xhi |=> $stable(page_table_base)
            && xlo_rd[31:4] == $past(exc_vaddr[38:11]))
        else $error("miss context update disturbed table base");

    chk_swirq_raise: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_cause && pwdata[8] && irq_mask[0] && status[ST_IE] && lvl_clear
            && !exc_valid && !wr_status && !soft_reset_req |=> irq_request)
        else $error("software interrupt not raised");

endmodule : ces_exception_state

//--- inc/ces_pkg.sv
// Register map, field layout, reset values and codes of the exception state block
package ces_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam int AW = 8;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CAUSE = 8'h04;
    localparam logic [7:0] ADDR_RET_LO = 8'h08;
    localparam logic [7:0] ADDR_RET_HI = 8'h0C;
    localparam logic [7:0] ADDR_WATCH_LO = 8'h10;
    localparam logic [7:0] ADDR_WATCH_HI = 8'h14;
    localparam logic [7:0] ADDR_XCTX_LO = 8'h18;
    localparam logic [7:0] ADDR_XCTX_HI = 8'h1C;
    localparam logic [7:0] ADDR_COMPARE = 8'h20;
    localparam logic [7:0] ADDR_COUNT = 8'h24;
    // ------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------
    localparam int ST_IE = 0;
    localparam int ST_EXC_LVL = 1;
    localparam int ST_ERR_LVL = 2;
    localparam int ST_PRIV_LO = 3;
    localparam int ST_U_WIDE = 5;
    localparam int ST_S_WIDE = 6;
    localparam int ST_K_WIDE = 7;
    localparam int ST_MASK_LO = 8;
    localparam int ST_SOFT = 20;
    localparam int ST_SHUT = 21;
    localparam int ST_BOOT = 22;
    localparam logic [31:0] STATUS_WMASK = 32'h1057_FFFF;
    localparam logic [31:0] STATUS_RST = 32'h0040_0004;
    // ------------------------------------------------------------
    // Cause field positions and codes
    // ------------------------------------------------------------
    localparam int CA_CODE_LO = 2;
    localparam int CA_PEND_LO = 8;
    localparam int CA_CE_LO = 28;
    localparam int CA_DELAY = 31;
    localparam logic [4:0] CODE_INT = 5'h00;
    localparam logic [4:0] CODE_PAGE_MOD = 5'h01;
    localparam logic [4:0] CODE_MAP_MISS_LOAD = 5'h02;
    localparam logic [4:0] CODE_MAP_MISS_STORE = 5'h03;
    localparam logic [4:0] CODE_MISALIGNED_LOAD = 5'h04;
    localparam logic [4:0] CODE_MISALIGNED_STORE = 5'h05;
    localparam logic [4:0] CODE_FETCH_BUS = 5'h06;
    localparam logic [4:0] CODE_DATA_BUS = 5'h07;
    localparam logic [4:0] CODE_SYSCALL = 5'h08;
    localparam logic [4:0] CODE_DEBUG_BREAK = 5'h09;
    localparam logic [4:0] CODE_BAD_OPCODE = 5'h0A;
    localparam logic [4:0] CODE_COP_UNUSABLE = 5'h0B;
    localparam logic [4:0] CODE_ARITH_WRAP = 5'h0C;
    localparam logic [4:0] CODE_CONDITIONAL = 5'h0D;
    localparam logic [4:0] CODE_WATCH = 5'h17;
    // ------------------------------------------------------------
    // Address space types and privilege codes
    // ------------------------------------------------------------
    localparam logic [1:0] SPACE_USER = 2'h0;
    localparam logic [1:0] SPACE_SUPV = 2'h1;
    localparam logic [1:0] SPACE_KERN = 2'h3;
    localparam logic [1:0] PRIV_USER = 2'h2;
    localparam logic [1:0] PRIV_SUPV = 2'h1;
endpackage : ces_pkg

//--- verif/ces_pipe_model.sv
// Pipeline and interrupt source model for the exception state bench
`timescale 1ns/1ps
module ces_pipe_model (
    // Clock
    input wire logic clk_sys,
    // Exception entry and return
    output logic exc_valid,
    output logic [4:0] exc_code,
    output logic exc_in_delay,
    output logic [63:0] exc_pc,
    output logic [63:0] exc_branch_pc,
    output logic [1:0] exc_cop_num,
    output logic exc_map_miss,
    output logic [63:0] exc_vaddr,
    output logic exc_return,
    // Request lines and memory reference
    output logic [4:0] irq_lines,
    output logic mem_valid,
    output logic mem_is_load,
    output logic mem_is_store,
    output logic [31:0] mem_paddr
);
    initial {exc_valid, exc_code, exc_in_delay, exc_pc, exc_branch_pc, exc_cop_num,
        exc_map_miss, exc_vaddr, exc_return, irq_lines, mem_valid, mem_is_load,
        mem_is_store, mem_paddr} = '0;
    // PCs and vaddr inverted after the pulse so a late read shows up
    task automatic exc(input logic [4:0] c, input logic d, input logic [1:0] cp,
        input logic m, input logic [63:0] pc, input logic [63:0] bpc, input logic [63:0] va);
        @(posedge clk_sys);
        {exc_valid, exc_code, exc_in_delay, exc_cop_num, exc_map_miss} <= {1'h1, c, d, cp, m};
        {exc_pc, exc_branch_pc, exc_vaddr} <= {pc, bpc, va};
        @(posedge clk_sys);
        exc_valid <= 1'h0;
        {exc_pc, exc_branch_pc, exc_vaddr} <= ~{pc, bpc, va};
    endtask : exc
    task automatic side(input logic r, input logic [3:0] v);
        @(posedge clk_sys);
        exc_return <= r;
        irq_lines <= {1'h0, v};
        @(posedge clk_sys);
        exc_return <= 1'h0;
    endtask : side
    task automatic mref(input logic ld, input logic st, input logic [31:0] pa);
        @(posedge clk_sys);
        {mem_valid, mem_is_load, mem_is_store, mem_paddr} <= {ld | st, ld, st, pa};
    endtask : mref
endmodule : ces_pipe_model

//--- verif/tb_ces_exception_state.sv
// Self-checking bench for the exception state block
`timescale 1ns/1ps
module tb_ces_exception_state;
    import ces_pkg::*;
    logic clk_sys = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic soft_reset_req = 1'h0, map_shutdown_req = 1'h0;
    logic [1:0] acc_space = 2'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, mem_paddr;
    logic pready, pslverr, serr, irq_request, watch_hit, acc_allowed, mode_kernel;
    logic mode_supv, mode_user, wide_addr_ok, wide_ops_ok, exception_level, error_level;
    logic boot_vector_sel, map_shutdown_flag, exc_valid, exc_in_delay, exc_map_miss;
    logic exc_return, mem_valid, mem_is_load, mem_is_store;
    logic [4:0] exc_code, irq_lines;
    logic [1:0] exc_cop_num;
    logic [63:0] exc_pc, exc_branch_pc, exc_vaddr;
    int errors = 0, checked = 0;
    always #20 clk_sys = ~clk_sys;
    ces_exception_state dut_u (.*);
    ces_pipe_model pm_u (.*);
    task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
        checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic close_out;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge clk_sys);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'h1 && n < 64);
        {rd, serr} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
        if (pready !== 1'h1) begin
            chk(0, 1, "apb wait");
            close_out();
        end
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m,
        input logic [31:0] k = 32'hFFFF_FFFF);
        apb(1'h0, a, 32'h0);
        chk(rd & k, e, m);
    endtask : rdc
    task automatic wchk(input logic ld, input logic st, input logic [31:0] pa, input logic e);
        pm_u.mref(ld, st, pa);
        @(negedge clk_sys);
        chk(watch_hit, e, "watch");
    endtask : wchk
    task automatic t_reset;
        rdc(ADDR_STATUS, 32'h0040_0004, "status reset");
        chk(mode_kernel, 1'h1, "reset kernel");
        rdc(ADDR_CAUSE, 32'h0000_2800, "lines to pending");
        apb(1'h0, 8'h30, 32'h0);
        chk({serr, rd}, 33'h1_0000_0000, "unmapped");
        $display("t_reset done");
    endtask : t_reset
    task automatic t_cause;
        apb(1'h1, ADDR_STATUS, 32'h0000_0101);
        apb(1'h1, ADDR_CAUSE, 32'hB000_FF7C);
        @(negedge clk_sys);
        chk(irq_request, 1'h1, "soft irq on");
        rdc(ADDR_CAUSE, 32'h0000_2B00, "cause write mask");
        apb(1'h1, ADDR_CAUSE, 32'h0);
        @(negedge clk_sys);
        chk(irq_request, 1'h0, "soft irq off");
        $display("t_cause done");
    endtask : t_cause
    task automatic t_mode;
        logic [31:0] st [4] = '{32'h30, 32'h08, 32'h12, 32'h80};
        logic [4:0] em [4] = '{5'h07, 5'h08, 5'h11, 5'h13};
        logic [2:0] ea [4] = '{3'h4, 3'h6, 3'h7, 3'h7};
        logic [1:0] sp [3] = '{SPACE_USER, SPACE_SUPV, SPACE_KERN};
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, ADDR_STATUS, st[i]);
            for (int j = 0; j < 3; j++) begin
                @(posedge clk_sys);
                acc_space <= sp[j];
                @(negedge clk_sys);
                chk(acc_allowed, ea[i][2-j], "space");
            end
            chk({mode_kernel, mode_supv, mode_user, wide_addr_ok, wide_ops_ok}, em[i], "mode");
        end
        $display("t_mode done");
    endtask : t_mode
    task automatic t_exc;
        apb(1'h1, ADDR_STATUS, 32'h0000_0010);
        pm_u.exc(CODE_SYSCALL, 1'h1, 2'h0, 1'h0, 64'h1000, 64'h0FFC, 64'h0);
        @(negedge clk_sys);
        chk({exception_level, mode_kernel}, 2'h3, "entry");
        rdc(ADDR_CAUSE, 32'h8000_2820, "delay cause", 32'hCFFF_FFFF);
        rdc(ADDR_RET_LO, 32'h0000_0FFC, "ret pc branch");
        pm_u.exc(CODE_COP_UNUSABLE, 1'h0, 2'h2, 1'h0, 64'h2000, 64'h1FFC, 64'h0);
        rdc(ADDR_CAUSE, 32'h2000_282C, "cop cause");
        rdc(ADDR_RET_LO, 32'h0000_0FFC, "ret pc kept");
        pm_u.side(1'h1, 4'hA);
        @(negedge clk_sys);
        chk({exception_level, mode_user}, 2'h1, "return");
        for (int c = 0; c < 24; c++) begin
            if (c < 14 || c == 23) begin
                pm_u.exc(5'(c), 1'h0, 2'h0, 1'h0, 64'h3000, 64'h2FFC, 64'h0);
                rdc(ADDR_CAUSE, 32'(c) << 2, "code", 32'h0000_007C);
            end
        end
        rdc(ADDR_RET_LO, 32'h0000_3000, "ret pc direct");
        $display("t_exc done");
    endtask : t_exc
    task automatic t_watch;
        apb(1'h1, ADDR_WATCH_LO, 32'h0000_123A);
        wchk(1'h1, 1'h0, 32'h0000_123C, 1'h1);
        wchk(1'h0, 1'h1, 32'h0000_123C, 1'h0);
        wchk(1'h1, 1'h0, 32'h0000_1230, 1'h0);
        apb(1'h1, ADDR_WATCH_LO, 32'h0000_1239);
        wchk(1'h0, 1'h1, 32'h0000_1238, 1'h1);
        wchk(1'h0, 1'h0, 32'h0000_1238, 1'h0);
        apb(1'h1, ADDR_WATCH_HI, 32'hFFFF_FFFF);
        rdc(ADDR_WATCH_HI, 32'h0000_000F, "watch high");
        $display("t_watch done");
    endtask : t_watch
    task automatic t_miss;
        logic [63:0] va;
        va = 64'hC000_00AB_CDEF_F800;
        apb(1'h1, ADDR_XCTX_HI, 32'hFFFF_FFF8);
        pm_u.exc(CODE_MAP_MISS_LOAD, 1'h0, 2'h0, 1'h1, 64'h4000, 64'h3FFC, va);
        rdc(ADDR_XCTX_LO, {va[38:11], 4'h0}, "page pair");
        rdc(ADDR_XCTX_HI, {29'h1FFF_FFFF, va[63:62], va[39]}, "space type");
        $display("t_miss done");
    endtask : t_miss
    task automatic t_timer;
        apb(1'h1, ADDR_COUNT, 32'h0);
        apb(1'h1, ADDR_COMPARE, 32'h0000_0040);
        repeat (80) @(posedge clk_sys);
        rdc(ADDR_CAUSE, 32'h0000_8000, "timer set", 32'h0000_8000);
        apb(1'h1, ADDR_COMPARE, 32'h0000_0040);
        rdc(ADDR_CAUSE, 32'h0, "timer clear", 32'h0000_8000);
        $display("t_timer done");
    endtask : t_timer
    task automatic t_soft;
        @(posedge clk_sys);
        map_shutdown_req <= 1'h1;
        @(posedge clk_sys);
        map_shutdown_req <= 1'h0;
        @(negedge clk_sys);
        chk(map_shutdown_flag, 1'h1, "shutdown set");
        @(posedge clk_sys);
        {soft_reset_req, map_shutdown_req} <= 2'h3;
        @(posedge clk_sys);
        {soft_reset_req, map_shutdown_req} <= 2'h0;
        rdc(ADDR_STATUS, 32'h0050_0004, "soft reset", 32'hEFF0_0004);
        chk({error_level, boot_vector_sel, map_shutdown_flag}, 3'h6, "soft pins");
        // Cold reset in mid-run must drop the soft-reset flag again
        @(posedge clk_sys);
        reset_n <= 1'h0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'h1;
        rdc(ADDR_STATUS, 32'h0040_0004, "cold after soft");
        $display("t_soft done");
    endtask : t_soft
    initial begin
        pm_u.side(1'h0, 4'hA);
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'h1;
        t_reset();
        t_cause();
        t_mode();
        t_exc();
        t_watch();
        t_miss();
        t_timer();
        t_soft();
        close_out();
    end
endmodule : tb_ces_exception_state
